// ===== design/bas_map.svh
`ifndef BAS_MAP_SVH
`define BAS_MAP_SVH

// clock rate and timing figures
`define BAS_CLK_HZ        40000000
`define BAS_STALL_MS0     250
`define BAS_STALL_MS1     500
`define BAS_STALL_MS2     1000
`define BAS_SEEK_STEP_MS  200

// stall power levels in tenths of a percent of full command
`define BAS_STALL_PWR0    100
`define BAS_STALL_PWR1    250
`define BAS_STALL_PWR2    500

// forced electrical angles, 512 is one electrical turn
`define BAS_ANGLE_P90     9'h080
`define BAS_ANGLE_M90     9'h180
`define BAS_SEEK_STEPS    6
`define BAS_SEEK_NEEDED   4
`define BAS_SEEK_FIRST_CHK 2

// speed: rpm = 60 * clk / (6 * poles * interval)
`define BAS_SPEED_NUM     32'h17D7_8400
`define BAS_IVL_MAX       24'hFF_FFFF

// field oriented control
`define BAS_INV_SQRT3     16'h49E7
`define BAS_PI_SHIFT      8
`define BAS_KP_DEFAULT    16'h0100
`define BAS_KI_DEFAULT    16'h0010
`define BAS_CHANNELS      1

`endif

// ===== design/bas_pkg.sv
package bas_pkg;

	// reference search sequencer, gray coded along idle, force, done
	typedef enum logic [1:0] {
		BAS_SEEK_IDLE  = 2'b00,
		BAS_SEEK_FORCE = 2'b01,
		BAS_SEEK_DONE  = 2'b11
	} bas_seek_state_t;

	typedef logic signed [15:0] bas_sample_t;

	typedef enum logic [2:0] {
		BAS_SENS_ENC     = 3'h0,
		BAS_SENS_HALL    = 3'h1,
		BAS_SENS_HALLENC = 3'h2,
		BAS_SENS_SPI     = 3'h3,
		BAS_SENS_SINCOS  = 3'h4,
		BAS_SENS_RESOLV  = 3'h5
	} bas_sensor_t;

endpackage

// ===== design/bas_pi_if.sv
`timescale 1ns/100ps
interface bas_pi_if;
	logic        run;
	logic [15:0] kp;
	logic [15:0] ki;
	bas_pkg::bas_sample_t setpoint;
	bas_pkg::bas_sample_t meas;
	bas_pkg::bas_sample_t out;

	modport ctl      (output run, kp, ki, setpoint, meas, input out);
	modport reg_side (input run, kp, ki, setpoint, meas, output out);
endinterface

// ===== design/bas_pi_reg.sv
`timescale 1ns/100ps
`include "bas_map.svh"
module bas_pi_reg
	import bas_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst,
	bas_pi_if.reg_side pi
);
	localparam logic signed [39:0] INT_MAX = 40'sh00_007F_FF00;
	localparam logic signed [39:0] INT_MIN = -INT_MAX;

	logic signed [39:0] integ_reg;
	logic signed [39:0] integ_next;
	bas_sample_t        out_reg;
	bas_sample_t        out_next;
	logic signed [16:0] err;
	logic signed [39:0] prop;
	logic signed [39:0] isum;
	logic signed [39:0] total;

	// error, integral with anti-windup clamp, then scaled output
	always_comb begin
		err        = 17'(pi.setpoint) - 17'(pi.meas);
		prop       = 40'($signed({1'b0, pi.kp})) * err;
		isum       = integ_reg + 40'($signed({1'b0, pi.ki})) * err;
		integ_next = isum;
		if (isum > INT_MAX) begin
			integ_next = INT_MAX;
		end else if (isum < INT_MIN) begin
			integ_next = INT_MIN;
		end
		if (!pi.run) begin
			integ_next = '0; // a stopped loop must not carry stale windup
		end
		total    = (prop + integ_next) >>> `BAS_PI_SHIFT;
		out_next = total[15:0];
		if (total > 40'sd32767) begin
			out_next = 16'h7FFF;
		end else if (total < -40'sd32768) begin
			out_next = 16'h8000;
		end
		if (!pi.run) begin
			out_next = '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			integ_reg <= '0;
			out_reg   <= '0;
		end else begin
			integ_reg <= integ_next;
			out_reg   <= out_next;
		end
	end

	assign pi.out = out_reg;
endmodule

// ===== design/bas_motor_logic.sv
// Overview of operation
// RULE1: seek current comes from tenths-of-amp setting
// RULE2: success reported; offset only with absolute sensors
// RULE3: failure reported; offset absent means noisy sensor
// RULE4: failed search sets bind fault, blocks drive
// RULE5: offset write or read clears bind fault
// RULE6: offset scale: 512 equals 360 degrees
// RULE7: three stall pairs: 250/10, 500/25, 1000/50
// RULE8: stall cuts power until command is zero
// RULE9: motion is Hall change or encoder speed
// RULE10: stall status output while cutoff active
// RULE11: Hall speed from transition interval and poles
// RULE12: negative pole count flips speed sign
// RULE13: Hall transitions counted up/down, 32 bits
// RULE14: absolute angle deltas accumulate, 32 bits
// RULE15: Park transform plus two PI current loops
// RULE16: host-writable gains with default values
// RULE17: gain index map depends on channel count
// RULE18: force +90/-90 six times, last four reached
// RULE19: stall timer restarts on motion or low power
`timescale 1ns/100ps
`include "bas_map.svh"
module bas_motor_logic
	import bas_pkg::*;
#(
	parameter int CHANNELS   = `BAS_CHANNELS,
	parameter int THIS_CH    = 0,
	parameter int STALL_CYC0 = `BAS_STALL_MS0 * (`BAS_CLK_HZ / 1000),
	parameter int STALL_CYC1 = `BAS_STALL_MS1 * (`BAS_CLK_HZ / 1000),
	parameter int STALL_CYC2 = `BAS_STALL_MS2 * (`BAS_CLK_HZ / 1000),
	parameter int SEEK_CYC   = `BAS_SEEK_STEP_MS * (`BAS_CLK_HZ / 1000)
)(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [2:0]        hall_in,
	input  wire logic [2:0]        sensor_mode,
	input  wire logic              sinusoidal,
	input  wire logic signed [7:0] pole_count,
	input  wire logic [8:0]        rotor_angle,
	input  wire logic              angle_valid,
	input  wire logic signed [15:0] enc_speed,
	input  wire logic signed [10:0] motor_cmd,
	input  wire logic [7:0]        seek_current_level,
	input  wire logic              bind_start,
	input  wire logic              rotor_at_target,
	input  wire logic              offset_write,
	input  wire logic [8:0]        offset_wdata,
	input  wire logic              offset_read,
	input  wire logic [1:0]        stall_guard_select,
	input  wire logic              foc_enable,
	input  wire bas_sample_t       phase_a_current,
	input  wire bas_sample_t       phase_b_current,
	input  wire bas_sample_t       torque_setpoint,
	input  wire bas_sample_t       flux_setpoint,
	input  wire logic              gain_wr,
	input  wire logic              gain_is_int,
	input  wire logic [2:0]        gain_index,
	input  wire logic [15:0]       gain_data,
	output logic                   seek_drive,
	output logic [8:0]             force_angle,
	output logic [7:0]             seek_current,
	output logic                   bind_done,
	output logic                   bind_ok,
	output logic                   offset_reported,
	output logic [8:0]             zero_angle_offset,
	output logic                   zero_angle_bind,
	output logic                   motor_drive_en,
	output logic                   stall_active,
	output logic signed [31:0]     motor_speed,
	output logic signed [31:0]     position_count,
	output bas_sample_t            torque_current,
	output bas_sample_t            flux_current,
	output bas_sample_t            flux_volt,
	output bas_sample_t            torque_volt
);
	localparam int SLOTS = 2 * CHANNELS;

	generate
		if (CHANNELS < 1 || CHANNELS > 2 || THIS_CH >= CHANNELS || SEEK_CYC < 1 ||
			STALL_CYC2 > 67108863 || SEEK_CYC > 67108863) begin : g_bad
			$error("bas_motor_logic: unsupported parameter values");
		end
	endgenerate

	localparam logic [15:0] SIN_TAB [0:16] = '{16'h0000, 16'h0C8C, 16'h18F9, 16'h2528,
		16'h30FC, 16'h3C57, 16'h471D, 16'h5134, 16'h5A82, 16'h62F2, 16'h6A6E,
		16'h70E3, 16'h7642, 16'h7A7D, 16'h7D8A, 16'h7F62, 16'h7FFF};

	function automatic logic is_abs(input logic [2:0] m);
		return m >= BAS_SENS_SPI;
	endfunction

	// hall code to sector 0..5; 7 marks an illegal code
	function automatic logic [2:0] hall_pos(input logic [2:0] h);
		case (h)
			3'h1: hall_pos = 3'h0;
			3'h5: hall_pos = 3'h1;
			3'h4: hall_pos = 3'h2;
			3'h6: hall_pos = 3'h3;
			3'h2: hall_pos = 3'h4;
			3'h3: hall_pos = 3'h5;
			default: hall_pos = 3'h7;
		endcase
	endfunction

	// sine of a 512-step angle, coarse 64-step table is ample for current sensing
	function automatic bas_sample_t sin9(input logic [8:0] a);
		logic [15:0] t;
		t = a[7] ? SIN_TAB[5'(16 - a[6:3])] : SIN_TAB[a[6:3]];
		sin9 = a[8] ? -$signed(t) : $signed(t);
	endfunction

	function automatic bas_sample_t sat16(input logic signed [35:0] v);
		if (v > 36'sd32767) begin
			sat16 = 16'h7FFF;
		end else if (v < -36'sd32768) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction

	// gain index 1..2*channels maps straight to a slot; flux slots first
	function automatic logic [3:0] gain_slot(input logic [2:0] idx);
		gain_slot = (idx >= 3'h1 && 32'(idx) <= SLOTS) ? {1'b1, 3'(idx - 3'h1)} : 4'h0;
	endfunction

	// pin synchroniser: first stage feeds only the second
	logic [2:0] hall_s1_reg;
	logic [2:0] hall_s2_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hall_s1_reg <= '0;
			hall_s2_reg <= '0;
		end else begin
			hall_s1_reg <= hall_in;
			hall_s2_reg <= hall_s1_reg;
		end
	end

	// ---------------- reference search and bind fault
	bas_seek_state_t seek_state_reg, seek_state_next;
	logic [2:0]  step_reg, step_next, reach_reg, reach_next;
	logic [25:0] seek_cnt_reg, seek_cnt_next;
	logic        done_reg, done_next, ok_reg, ok_next;
	logic        rep_reg, rep_next, bind_reg, bind_next, drive_reg, drive_next;
	logic [8:0]  offs_reg, offs_next, fang_reg, fang_next;
	logic [7:0]  scur_reg, scur_next;
	logic        stall_reg;
	logic        hit;

	always_comb begin
		seek_state_next = seek_state_reg;
		step_next       = step_reg;
		reach_next      = reach_reg;
		seek_cnt_next   = seek_cnt_reg;
		ok_next         = ok_reg;
		rep_next        = rep_reg;
		offs_next       = offs_reg;
		done_next       = 1'b0;
		bind_next       = bind_reg;
		hit             = 1'b0;
		if (offset_write) begin
			offs_next = offset_wdata; //RULE5
		end
		if (offset_write || offset_read) begin
			bind_next = 1'b0; //RULE5
		end
		case (seek_state_reg)
			BAS_SEEK_IDLE: begin
				if (bind_start) begin
					seek_state_next = BAS_SEEK_FORCE;
					step_next       = '0;
					reach_next      = '0;
					seek_cnt_next   = '0;
				end
			end
			BAS_SEEK_FORCE: begin
				seek_cnt_next = seek_cnt_reg + 26'h1;
				if (seek_cnt_reg == 26'(SEEK_CYC - 1)) begin
					seek_cnt_next = '0;
					hit = rotor_at_target && step_reg >= 3'(`BAS_SEEK_FIRST_CHK);
					reach_next = reach_reg + {2'h0, hit}; //RULE18
					if (step_reg == 3'(`BAS_SEEK_STEPS - 1)) begin
						seek_state_next = BAS_SEEK_DONE;
						ok_next = reach_next == 3'(`BAS_SEEK_NEEDED); //RULE18
						if (angle_valid) begin
							offs_next = rotor_angle - `BAS_ANGLE_M90; //RULE6
						end
						rep_next = angle_valid && (!ok_next || is_abs(sensor_mode)); //RULE2 RULE3
						if (!ok_next) begin
							bind_next = 1'b1; //RULE4
						end
					end else begin
						step_next = step_reg + 3'h1;
					end
				end
			end
			BAS_SEEK_DONE: begin
				seek_state_next = BAS_SEEK_IDLE;
				done_next       = 1'b1; //RULE3
			end
			default: begin
				seek_state_next = BAS_SEEK_IDLE;
			end
		endcase
		drive_next = (seek_state_next == BAS_SEEK_FORCE);
		fang_next  = step_next[0] ? `BAS_ANGLE_M90 : `BAS_ANGLE_P90; //RULE18
		scur_next  = drive_next ? seek_current_level : 8'h00; //RULE1
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seek_state_reg <= BAS_SEEK_IDLE;
			step_reg       <= '0;
			reach_reg      <= '0;
			seek_cnt_reg   <= '0;
			ok_reg         <= 1'b0;
			rep_reg        <= 1'b0;
			offs_reg       <= '0;
			done_reg       <= 1'b0;
			bind_reg       <= 1'b0;
			drive_reg      <= 1'b0;
			fang_reg       <= `BAS_ANGLE_P90;
			scur_reg       <= '0;
		end else begin
			seek_state_reg <= seek_state_next;
			step_reg       <= step_next;
			reach_reg      <= reach_next;
			seek_cnt_reg   <= seek_cnt_next;
			ok_reg         <= ok_next;
			rep_reg        <= rep_next;
			offs_reg       <= offs_next;
			done_reg       <= done_next;
			bind_reg       <= bind_next;
			drive_reg      <= drive_next;
			fang_reg       <= fang_next;
			scur_reg       <= scur_next;
		end
	end

	// ---------------- stall guard and drive enable
	logic [25:0] stall_cnt_reg, stall_cnt_next, stall_lim;
	logic [9:0]  power_mag, stall_thr;
	logic        stall_next, motion, en_reg, en_next, hall_chg;
	logic [2:0]  hall_prev_reg;

	assign hall_chg = hall_s2_reg != hall_prev_reg;

	always_comb begin
		stall_lim = '0;
		stall_thr = '0;
		case (stall_guard_select)
			2'h1: begin
				stall_lim = 26'(STALL_CYC0); //RULE7
				stall_thr = 10'(`BAS_STALL_PWR0);
			end
			2'h2: begin
				stall_lim = 26'(STALL_CYC1); //RULE7
				stall_thr = 10'(`BAS_STALL_PWR1);
			end
			2'h3: begin
				stall_lim = 26'(STALL_CYC2); //RULE7
				stall_thr = 10'(`BAS_STALL_PWR2);
			end
			default: begin
				stall_lim = '0;
			end
		endcase
		power_mag = motor_cmd[10] ? 10'(-motor_cmd) : motor_cmd[9:0];
		motion = sinusoidal ? (enc_speed != '0) : hall_chg; //RULE9
		stall_next = stall_reg;
		stall_cnt_next = stall_cnt_reg + 26'h1;
		if (stall_guard_select == 2'h0 || motion || power_mag <= stall_thr) begin
			stall_cnt_next = '0; //RULE19
		end else if (stall_cnt_reg >= stall_lim - 26'h1) begin
			stall_cnt_next = '0;
			stall_next = 1'b1; //RULE8
		end
		if (motor_cmd == '0) begin
			stall_next = 1'b0; //RULE8
		end
		// bind fault, active stall and a running search all keep phases dead
		en_next = !bind_reg && !stall_reg && !drive_reg && motor_cmd != '0; //RULE4
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stall_cnt_reg <= '0;
			stall_reg     <= 1'b0;
			en_reg        <= 1'b0;
		end else begin
			stall_cnt_reg <= stall_cnt_next;
			stall_reg     <= stall_next; //RULE10
			en_reg        <= en_next;
		end
	end

	// ---------------- hall interval speed and position counting
	logic [23:0]        ivl_reg, ivl_next;
	logic [31:0]        den_reg, den_next, num_reg, num_next, quo_reg, quo_next;
	logic [32:0]        rem_reg, rem_next, rem_try;
	logic [5:0]         dcnt_reg, dcnt_next;
	logic               busy_reg, busy_next, neg_reg, neg_next;
	logic signed [31:0] speed_reg, speed_next, pos_reg, pos_next;
	logic [8:0]         ang_prev_reg, dang;
	logic [2:0]         pnew, pold, pdiff;
	logic signed [1:0]  dir;
	logic [6:0]         poles_mag;

	always_comb begin
		pnew      = hall_pos(hall_s2_reg);
		pold      = hall_pos(hall_prev_reg);
		pdiff     = (pnew >= pold) ? pnew - pold : 3'(pnew + 3'h6 - pold);
		dir       = 2'sd0;
		if (hall_chg && pnew != 3'h7 && pold != 3'h7) begin
			dir = (pdiff == 3'h1) ? 2'sd1 : (pdiff == 3'h5) ? -2'sd1 : 2'sd0;
		end
		poles_mag = pole_count[7] ? 7'(-pole_count) : pole_count[6:0];
		ivl_next  = (ivl_reg == `BAS_IVL_MAX) ? ivl_reg : ivl_reg + 24'h1;
		den_next  = den_reg;
		num_next  = {num_reg[30:0], 1'b0};
		rem_try   = {rem_reg[31:0], num_reg[31]};
		rem_next  = rem_try;
		quo_next  = {quo_reg[30:0], 1'b0};
		dcnt_next = dcnt_reg;
		busy_next = busy_reg;
		neg_next  = neg_reg;
		speed_next = speed_reg;
		if (busy_reg) begin
			// one quotient bit per clock keeps the divider small
			if (rem_try >= {1'b0, den_reg}) begin
				rem_next = rem_try - {1'b0, den_reg};
				quo_next[0] = 1'b1;
			end
			dcnt_next = dcnt_reg - 6'h1;
			if (dcnt_reg == 6'h1) begin
				busy_next  = 1'b0;
				speed_next = neg_reg ? -$signed(quo_next) : $signed(quo_next); //RULE12
			end
		end
		if (dir != 2'sd0) begin
			ivl_next  = 24'h1;
			den_next  = 32'(ivl_reg) * poles_mag; //RULE11
			num_next  = `BAS_SPEED_NUM;
			rem_next  = '0;
			quo_next  = '0;
			dcnt_next = 6'd32;
			busy_next = poles_mag != '0;
			neg_next  = (dir < 0) ^ pole_count[7]; //RULE12
		end
		if (ivl_reg == `BAS_IVL_MAX || poles_mag == '0 || is_abs(sensor_mode)) begin
			speed_next = '0; // too slow to time, no pole count or absolute sensor: treat as stopped
		end
		dang     = rotor_angle - ang_prev_reg;
		pos_next = pos_reg;
		if (is_abs(sensor_mode)) begin
			if (angle_valid) begin
				pos_next = pos_reg + 32'($signed(dang)); //RULE14
			end
		end else begin
			pos_next = pos_reg + 32'(dir); //RULE13
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hall_prev_reg <= '0;
			ang_prev_reg  <= '0;
			ivl_reg       <= '0;
			den_reg       <= '0;
			num_reg       <= '0;
			rem_reg       <= '0;
			quo_reg       <= '0;
			dcnt_reg      <= '0;
			busy_reg      <= 1'b0;
			neg_reg       <= 1'b0;
			speed_reg     <= '0;
			pos_reg       <= '0;
		end else begin
			hall_prev_reg <= hall_s2_reg;
			ang_prev_reg  <= angle_valid ? rotor_angle : ang_prev_reg;
			ivl_reg       <= ivl_next;
			den_reg       <= den_next;
			num_reg       <= num_next;
			rem_reg       <= rem_next;
			quo_reg       <= quo_next;
			dcnt_reg      <= dcnt_next;
			busy_reg      <= busy_next;
			neg_reg       <= neg_next;
			speed_reg     <= speed_next;
			pos_reg       <= pos_next;
		end
	end

	// ---------------- field oriented current loops
	logic [15:0] kp_reg [SLOTS], kp_next [SLOTS], ki_reg [SLOTS], ki_next [SLOTS];
	bas_sample_t tq_reg, tq_next, fx_reg, fx_next, beta, sn, cs;
	logic [3:0]  slot;

	always_comb begin
		sn   = sin9(rotor_angle);
		cs   = sin9(rotor_angle + 9'h080);
		beta = sat16((36'(phase_a_current) + phase_b_current * 36'sd2) *
			$signed({1'b0, `BAS_INV_SQRT3}) >>> 15);
		fx_next = sat16((36'(phase_a_current) * cs + 36'(beta) * sn) >>> 15); //RULE15
		tq_next = sat16((36'(beta) * cs - 36'(phase_a_current) * sn) >>> 15); //RULE15
		slot = gain_slot(gain_index);
		for (int i = 0; i < SLOTS; i++) begin
			kp_next[i] = kp_reg[i];
			ki_next[i] = ki_reg[i];
			if (gain_wr && slot[3] && 32'(slot[2:0]) == i) begin
				if (gain_is_int) begin
					ki_next[i] = gain_data; //RULE17
				end else begin
					kp_next[i] = gain_data; //RULE17
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tq_reg <= '0;
			fx_reg <= '0;
			for (int i = 0; i < SLOTS; i++) begin
				kp_reg[i] <= `BAS_KP_DEFAULT; //RULE16
				ki_reg[i] <= `BAS_KI_DEFAULT; //RULE16
			end
		end else begin
			tq_reg <= tq_next;
			fx_reg <= fx_next;
			kp_reg <= kp_next;
			ki_reg <= ki_next;
		end
	end

	// regulator 0 holds flux, regulator 1 torque
	bas_pi_if pi_bus [2] ();
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pi
			assign pi_bus[g].run      = foc_enable && en_reg;
			assign pi_bus[g].kp       = kp_reg[g * CHANNELS + THIS_CH];
			assign pi_bus[g].ki       = ki_reg[g * CHANNELS + THIS_CH];
			assign pi_bus[g].setpoint = (g == 0) ? flux_setpoint : torque_setpoint;
			assign pi_bus[g].meas     = (g == 0) ? fx_reg : tq_reg;
			bas_pi_reg u_pi (
				.clk (clk),
				.rst (rst),
				.pi  (pi_bus[g].reg_side)
			);
		end
	endgenerate

	assign seek_drive        = drive_reg;
	assign force_angle       = fang_reg;
	assign seek_current      = scur_reg;
	assign bind_done         = done_reg;
	assign bind_ok           = ok_reg;
	assign offset_reported   = rep_reg;
	assign zero_angle_offset = offs_reg;
	assign zero_angle_bind   = bind_reg;
	assign motor_drive_en    = en_reg;
	assign stall_active      = stall_reg;
	assign motor_speed       = speed_reg;
	assign position_count    = pos_reg;
	assign torque_current    = tq_reg;
	assign flux_current      = fx_reg;
	assign flux_volt         = pi_bus[0].out;
	assign torque_volt       = pi_bus[1].out;
endmodule

// ===== tb/bas_motor_model.sv
`timescale 1ns/100ps
// motor stand-in: rotor follows forced angles unless loaded, hall code steps on spin
module bas_motor_model #(
	parameter logic [8:0] OFS = 9'h011
)(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       seek_drive,
	input  wire logic [8:0] force_angle,
	input  wire logic       stuck,
	input  wire logic       noisy,
	input  wire logic       spin,
	input  wire logic       rev,
	output logic [2:0]      hall_in,
	output logic [8:0]      rotor_angle,
	output logic            angle_valid,
	output logic            rotor_at_target
);
	localparam logic [17:0] SEQ = {3'h3, 3'h2, 3'h6, 3'h4, 3'h5, 3'h1};
	logic [2:0] pos_reg;

	// a loaded rotor keeps its old angle, so only targets equal to that angle are reached
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pos_reg <= 3'h0;
			rotor_angle <= 9'h000;
		end else if (seek_drive && !stuck) begin
			rotor_angle <= force_angle + OFS;
		end else if (spin) begin
			pos_reg <= rev ? (pos_reg == 3'h0 ? 3'h5 : pos_reg - 3'h1)
				: (pos_reg == 3'h5 ? 3'h0 : pos_reg + 3'h1);
			rotor_angle <= rev ? rotor_angle - 9'h040 : rotor_angle + 9'h040;
		end
	end
	assign hall_in = SEQ[pos_reg * 3 +: 3];
	assign rotor_at_target = seek_drive && rotor_angle == force_angle + OFS;
	assign angle_valid = !noisy; // noise leaves no usable angle
endmodule

// ===== tb/bas_motor_checker.sv
`timescale 1ns/100ps
module bas_motor_checker #(
	parameter int SEEK_CYC = 20
)(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              bind_start,
	input wire logic [7:0]        seek_current_level,
	input wire logic              offset_write,
	input wire logic              offset_read,
	input wire logic signed [10:0] motor_cmd,
	input wire logic              seek_drive,
	input wire logic [8:0]        force_angle,
	input wire logic [7:0]        seek_current,
	input wire logic              bind_done,
	input wire logic              bind_ok,
	input wire logic              zero_angle_bind,
	input wire logic              motor_drive_en,
	input wire logic              stall_active
);
	int cnt_reg;
	int cnt_next;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// drive length counter, checked as a whole when the search ends
	always_comb cnt_next = seek_drive ? cnt_reg + 1 : 0;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	a_seek_start_p90: assert property ($rose(seek_drive) |-> $past(bind_start)
		&& force_angle == 9'h080) else $error("search start wrong");
	a_seek_length: assert property ($fell(seek_drive) |-> cnt_reg == 6 * SEEK_CYC)
		else $error("search length wrong");
	a_seek_current: assert property (seek_current == (seek_drive ? seek_current_level
		: 8'h00)) else $error("seek current wrong");
	a_done_pulse: assert property ($fell(seek_drive) |=> bind_done ##1 !bind_done)
		else $error("done pulse wrong");
	a_fail_sets_bind: assert property (bind_done && !bind_ok |-> zero_angle_bind)
		else $error("bind fault not set");
	a_bind_blocks_drive: assert property (zero_angle_bind && $past(zero_angle_bind)
		|-> !motor_drive_en) else $error("drive during bind fault");
	a_access_clears: assert property ((offset_write || offset_read) && !seek_drive
		|=> !zero_angle_bind) else $error("bind fault not cleared");
	a_stall_holds: assert property (stall_active && motor_cmd != 0 |=> stall_active
		&& !motor_drive_en) else $error("stall released early");

	c_ok: cover property (bind_done && bind_ok);
	c_fail: cover property (bind_done && !bind_ok);
	c_stall: cover property ($rose(stall_active));
endmodule

bind bas_motor_logic bas_motor_checker #(.SEEK_CYC(SEEK_CYC)) chk_u (.*);

// ===== tb/bas_motor_logic_tb.sv
`timescale 1ns/100ps
module bas_motor_logic_tb;
	import bas_pkg::*;
	localparam logic [8:0] OFS = 9'h011;
	logic clk, rst, sinusoidal, angle_valid, bind_start, rotor_at_target, offset_write;
	logic offset_read, foc_enable, gain_wr, gain_is_int, stuck, noisy, spin, rev;
	logic seek_drive, bind_done, bind_ok, offset_reported, zero_angle_bind;
	logic motor_drive_en, stall_active;
	logic [2:0] hall_in, sensor_mode, gain_index;
	logic signed [7:0] pole_count;
	logic [8:0] rotor_angle, offset_wdata, force_angle, zero_angle_offset;
	logic signed [15:0] enc_speed;
	logic signed [10:0] motor_cmd;
	logic [7:0] seek_current_level, seek_current;
	logic [1:0] stall_guard_select;
	logic [15:0] gain_data;
	logic signed [31:0] motor_speed, position_count, p0;
	bas_sample_t phase_a_current, phase_b_current, torque_setpoint, flux_setpoint;
	bas_sample_t torque_current, flux_current, flux_volt, torque_volt;
	int failures, compares;

	bas_motor_logic #(.STALL_CYC0(40), .STALL_CYC1(100), .STALL_CYC2(200), .SEEK_CYC(20))
		dut_u (.*);
	bas_motor_model #(.OFS(OFS)) mdl_u (.*);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		compares++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %0h got %0h", n, e, s);
		end
	endtask

	// tolerance allows for fixed-point rounding in the transform
	task automatic rng(string n, logic signed [31:0] lo, logic signed [31:0] hi, bas_sample_t v);
		compares++;
		if ((v >= lo && v <= hi) !== 1'b1) begin
			failures++;
			$display("CHECK FAILED %s exp %0d..%0d got %0d", n, lo, hi, v);
		end
	endtask

	task automatic wait_hi(ref logic s, input int lim);
		int n;
		n = 0;
		while (s !== 1'b1) begin
			if (n == lim) begin
				failures++;
				$display("CHECK FAILED wait exp 1 got %b", s);
				give_verdict();
			end
			step(1);
			n++;
		end
	endtask

	task automatic gain(logic i, logic [2:0] x, logic [15:0] d);
		@(posedge clk);
		gain_wr <= 1'b1;
		gain_is_int <= i;
		gain_index <= x;
		gain_data <= d;
		@(posedge clk);
		gain_wr <= 1'b0;
	endtask

	// angle 0 and b = -a/2 make the torque axis read zero
	task automatic t_foc();
		gain(1'b1, 3'h1, 16'h0000);
		gain(1'b1, 3'h2, 16'h0000);
		gain(1'b0, 3'h1, 16'h0200);
		gain(1'b0, 3'h2, 16'h0200);
		gain(1'b0, 3'h3, 16'h0000);
		phase_a_current <= 16'sd1000;
		phase_b_current <= -16'sd500;
		torque_setpoint <= 16'sd300;
		motor_cmd <= 11'sd50;
		foc_enable <= 1'b1;
		step(8);
		rng("flux_current", 999, 1001, flux_current);
		rng("torque_current", -1, 1, torque_current);
		rng("flux_volt", -2004, -1996, flux_volt);
		rng("torque_volt", 596, 604, torque_volt);
		@(posedge clk);
		{foc_enable, motor_cmd} <= '0;
	endtask

	task automatic t_search(logic [2:0] m, logic s, logic nz, logic ok, logic rep);
		@(posedge clk);
		sensor_mode <= m;
		stuck <= s;
		noisy <= nz;
		bind_start <= 1'b1;
		@(posedge clk);
		bind_start <= 1'b0;
		wait_hi(bind_done, 200);
		chk("bind_ok", ok, bind_ok);
		chk("offset_reported", rep, offset_reported);
		chk("zero_angle_bind", !ok, zero_angle_bind);
		if (ok && rep) begin
			chk("zero_angle_offset", OFS, zero_angle_offset);
		end
		if (!ok) begin
			@(posedge clk);
			motor_cmd <= 11'sd200;
			step(3);
			chk("motor_drive_en", 0, motor_drive_en);
			offset_write <= nz;
			offset_read <= !nz;
			offset_wdata <= 9'h1A5;
			@(posedge clk);
			{offset_write, offset_read, motor_cmd} <= '0;
			step(2);
			chk("zero_angle_bind", 0, zero_angle_bind);
		end
	endtask

	// hall steps spaced 100 cycles apart fix the measured interval
	task automatic turn(int n, logic r);
		repeat (n) begin
			repeat (99) @(posedge clk);
			spin <= 1'b1;
			rev <= r;
			@(posedge clk);
			spin <= 1'b0;
		end
		step(40);
	endtask

	task automatic t_stall(logic [1:0] sel, logic signed [10:0] cmd, int lim);
		@(posedge clk);
		stall_guard_select <= sel;
		motor_cmd <= cmd;
		step(lim - 3);
		chk("stall_active", 0, stall_active);
		wait_hi(stall_active, 8);
		step(1); // drive enable trails the stall flag by one register
		chk("motor_drive_en", 0, motor_drive_en);
		motor_cmd <= 11'sd0;
		step(3);
		chk("stall_active", 0, stall_active);
	endtask

	initial begin
		{rst, sinusoidal, bind_start, offset_write, offset_read, foc_enable, gain_wr} = 7'h01;
		{gain_is_int, stuck, noisy, spin, rev, sensor_mode, gain_index, offset_wdata} = '0;
		{enc_speed, motor_cmd, stall_guard_select, phase_a_current, phase_b_current} = '0;
		{torque_setpoint, flux_setpoint, gain_data, failures, compares} = '0;
		seek_current_level = 8'h2D;
		pole_count = 8'sd4;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		step(1);
		chk("force_angle", 9'h080, force_angle);
		t_foc();
		t_search(3'h3, 1'b0, 1'b0, 1'b1, 1'b1);
		t_search(3'h1, 1'b0, 1'b0, 1'b1, 1'b0);
		t_search(3'h0, 1'b1, 1'b0, 1'b0, 1'b1);
		t_search(3'h5, 1'b1, 1'b1, 1'b0, 1'b0);
		chk("zero_angle_offset", 9'h1A5, zero_angle_offset);
		{sensor_mode, stuck, noisy} <= 5'h04; // free rotor, clean angle for counting
		step(3);
		p0 = position_count;
		turn(6, 1'b0);
		chk("position_count", p0 + 6, position_count);
		chk("motor_speed", 1000000, motor_speed);
		turn(3, 1'b1);
		chk("position_count", p0 + 3, position_count);
		chk("motor_speed", -1000000, motor_speed);
		pole_count <= -8'sd4;
		turn(2, 1'b0);
		chk("motor_speed", -1000000, motor_speed);
		sensor_mode <= 3'h3;
		step(3);
		p0 = position_count;
		turn(4, 1'b0);
		chk("position_count", p0 + 256, position_count);
		t_stall(2'h1, 11'sd101, 40);
		t_stall(2'h2, 11'sd251, 100);
		t_stall(2'h3, -11'sd501, 200);
		motor_cmd <= 11'sd100;
		stall_guard_select <= 2'h1;
		step(60);
		chk("stall_active", 0, stall_active);
		sinusoidal <= 1'b1;
		enc_speed <= 16'sd5;
		motor_cmd <= 11'sd150;
		step(60);
		chk("stall_active", 0, stall_active);
		enc_speed <= 16'sd0;
		wait_hi(stall_active, 50);
		give_verdict();
	end
endmodule
